// ==== core/pss_pkg.sv ====
// package for the power-state sequencer: register map, encodings, timing
package pss_pkg;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [11:0] PSS_CTRL_OFF    = 12'h000;
   localparam logic [11:0] PSS_STATUS_OFF  = 12'h004;
   localparam logic [11:0] PSS_LMEM_OFF    = 12'h008;
   localparam logic [11:0] PSS_SMEM_OFF    = 12'h00C;
   localparam logic [11:0] PSS_STORE_OFF   = 12'h010;
   localparam logic [11:0] PSS_WAKEEN_OFF  = 12'h014;
   localparam logic [11:0] PSS_VSEL_OFF    = 12'h018;

   // ************************************************************
   // field layout and reset values
   // ************************************************************
   localparam int LMEM_DOMAINS  = 10;
   localparam int SMEM_DOMAINS  = 4;
   localparam int STORE_SETS    = 3;
   localparam int VDOMAINS      = 7;
   localparam int WAKE_SRCS     = 16;
   localparam int VDOM_HIGH     = 1;
   localparam int VDOM_UULP     = 6;
   localparam logic [9:0]  LMEM_RESET   = 10'h3FF;
   localparam logic [3:0]  SMEM_RESET   = 4'hF;
   localparam logic [2:0]  STORE_RESET  = 3'h7;
   localparam logic [15:0] WAKEEN_RESET = 16'h0000;
   // domain sizes in KB, in order; storage flop set sizes in bytes
   localparam int LMEM_KB [LMEM_DOMAINS] = '{4, 4, 4, 4, 16, 32, 64, 64, 64, 64};
   localparam int SMEM_KB     = 2;
   localparam int STORE_BYTES [STORE_SETS] = '{8, 8, 16};

   // wakeup source groups per low-power family
   localparam logic [15:0] WAKE_STBY_MASK  = 16'hFFFF;
   localparam logic [15:0] WAKE_SLEEP_MASK = 16'h001F;
   localparam logic [15:0] WAKE_SLEEP_WP   = 16'h0020;
   localparam logic [15:0] WAKE_GATED_MASK = 16'h0300;
   localparam logic [15:0] WAKE_SHDN_MASK  = 16'h001F;

   // ************************************************************
   // encodings
   // ************************************************************
   typedef enum logic [1:0] {
      VSRC_OFF  = 2'b00,
      VSRC_MAIN = 2'b01,
      VSRC_SC   = 2'b10,
      VSRC_LV   = 2'b11
   } pss_vsrc_t;

   typedef enum logic [2:0] {
      REQ_NONE   = 3'h0,
      REQ_ACTIVE = 3'h1,
      REQ_STBY   = 3'h2,
      REQ_SLEEP  = 3'h3,
      REQ_SHDN   = 3'h4,
      REQ_GATED  = 3'h5
   } pss_req_t;

   typedef enum logic [3:0] {
      ST_RESET      = 4'h0,
      ST_TOP        = 4'h1,
      ST_MID        = 4'h2,
      ST_LOW        = 4'h3,
      ST_GATED      = 4'h4,
      ST_TOP_STBY   = 4'h5,
      ST_MID_STBY   = 4'h6,
      ST_LOW_STBY   = 4'h7,
      ST_TOP_SLEEP  = 4'h8,
      ST_MID_SLEEP  = 4'h9,
      ST_LOW_SLEEP  = 4'hA,
      ST_SHUTDOWN   = 4'hB,
      ST_ENTER      = 4'hC,
      ST_WAKE       = 4'hD
   } pss_state_t;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_MHZ        = 25;
   localparam int WAKE_TOP_NS    = 1200000;
   localparam int WAKE_TOP_CYC   = (WAKE_TOP_NS * CLK_MHZ) / 1000;
   localparam int WAKE_LOW_NS    = 200000;
   localparam int WAKE_LOW_CYC   = (WAKE_LOW_NS * CLK_MHZ) / 1000;
   localparam int ENTER_CYC      = 4;
   localparam int PLL_MAX_MHZ    = 180;

endpackage

// ==== core/pss_sequencer.sv ====
// power-state sequencer with APB register slave
// How it works
// - at reset every power domain is switched on before software gating applies
// - leaving reset the chip goes to full-performance active state
// - reset, four active, three standby, three sleep, one shutdown state, plus enter and wake transit states
// - active to standby or sleep only on explicit software request
// - low-power exit only when an enabled wakeup interrupt is asserted
// - wakeup returns to the active state the low-power state came from, except shutdown, which restarts in full performance
// - only wakeup sources allowed for the current low-power state count
// - standby via wait-for-interrupt gates processor clock, power kept
// - sleep to active return resets peripheral configuration to defaults
// - while active each memory domain can be powered down on its own
// - powered-down memory is marked lost, never treated as retained
// - deep-sleep retains no memory and blocks every memory access
// - large memory has ten domains: 4x4 KB, 16, 32, 4x64 KB
// - small memory has four 2 KB domains, one bank each
// - always-on group has three storage flop sets of 8, 8, 16 bytes
// - each voltage domain gets the source selected for current state
// - high-voltage domain only main regulator, always-on only switched-cap
// - entering sleep powers off domains whose source is main regulator
// - full-performance state may run processor from fast pll up to 180 MHz
// - wakeup into full-performance state takes about 1.2 ms
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module pss_sequencer
   import pss_pkg::*;
#(
   parameter int WAKE_LONG_CYC  = WAKE_TOP_CYC,  // full-performance wake latency
   parameter int WAKE_SHORT_CYC = WAKE_LOW_CYC   // reduced-state wake latency
) (
   input  wire logic        mclk,              // system clock, 25 MHz
   input  wire logic        rst_n,             // asynchronous reset, active low
   input  wire logic        psel,              // apb select
   input  wire logic        penable,           // apb access phase
   input  wire logic        pwrite,            // apb write
   input  wire logic [11:0] paddr,             // apb byte address
   input  wire logic [31:0] pwdata,            // apb write data
   output logic      [31:0] prdata,            // apb read data
   output logic             pready,            // apb ready
   output logic             pslverr,           // apb error
   input  wire logic        wait_for_interrupt_instruction, // core executes standby request
   input  wire logic [15:0] wake_irq,          // wakeup interrupt sources
   output logic             cpu_clk_en,        // processor clock enable
   output logic             cpu_pwr_en,        // processor power enable
   output logic             fast_pll_sel,      // processor runs from fast pll
   output logic             periph_cfg_rst,    // one-cycle peripheral config reset
   output logic [9:0]       large_memory_domains,   // large memory power enables
   output logic [3:0]       small_memory_domains,   // small memory power enables
   output logic [2:0]       storage_flop_sets, // storage flop set power enables
   output logic             sram_access_block, // memory accesses refused
   output logic [13:0]      sram_lost,         // contents lost per memory domain
   output logic [13:0]      vsrc_sel           // source per voltage domain, 2 bits each
);

   // ************************************************************
   // registers
   // ************************************************************
   pss_state_t  state_reg, origin_reg, target_reg;
   logic [20:0] cnt_reg;
   logic        wake_pend_reg;
   logic [2:0]  ctrl_req_reg;
   logic        pll_en_reg, deep_reg;
   logic [9:0]  lmem_reg;
   logic [3:0]  smem_reg;
   logic [2:0]  store_reg;
   logic [15:0] wakeen_reg;
   logic [13:0] vsel_reg;
   logic [13:0] lost_reg;

   wire logic wr = psel & penable & pwrite;
   wire logic rd_ok = (paddr <= PSS_VSEL_OFF) && (paddr[1:0] == 2'b00);

   function automatic logic is_active(pss_state_t s);
      return (s == ST_TOP) || (s == ST_MID) || (s == ST_LOW) || (s == ST_GATED);
   endfunction

   function automatic logic is_sleep(pss_state_t s);
      return (s == ST_TOP_SLEEP) || (s == ST_MID_SLEEP) || (s == ST_LOW_SLEEP);
   endfunction

   // allowed wakeup sources for a low-power state
   function automatic logic [15:0] allowed(pss_state_t s);
      unique case (s)
         ST_TOP_STBY, ST_MID_STBY, ST_LOW_STBY: return WAKE_STBY_MASK;
         ST_TOP_SLEEP, ST_MID_SLEEP:            return WAKE_SLEEP_MASK | WAKE_SLEEP_WP;
         ST_LOW_SLEEP:                          return WAKE_SLEEP_MASK;
         ST_GATED:                              return WAKE_GATED_MASK;
         ST_SHUTDOWN:                           return WAKE_SHDN_MASK;
         default:                               return 16'h0000;
      endcase
   endfunction

   function automatic pss_state_t low_of(pss_state_t a, logic [2:0] r);
      pss_state_t s;
      s = a;
      if (r == REQ_SHDN) begin
         s = ST_SHUTDOWN;
      end else if (r == REQ_GATED && a == ST_LOW) begin
         s = ST_GATED;
      end else if (r == REQ_STBY || r == REQ_SLEEP) begin
         unique case (a)
            ST_TOP:  s = (r == REQ_STBY) ? ST_TOP_STBY : ST_TOP_SLEEP;
            ST_MID:  s = (r == REQ_STBY) ? ST_MID_STBY : ST_MID_SLEEP;
            default: s = (r == REQ_STBY) ? ST_LOW_STBY : ST_LOW_SLEEP;
         endcase
      end
      return s;
   endfunction

   function automatic pss_state_t active_of(pss_state_t l);
      unique case (l)
         ST_TOP_STBY, ST_TOP_SLEEP: return ST_TOP;
         ST_MID_STBY, ST_MID_SLEEP: return ST_MID;
         ST_GATED:                  return ST_LOW;
         default:                   return ST_LOW;
      endcase
   endfunction

   wire logic wake_hit = |(wake_irq & wakeen_reg & allowed(target_reg));
   wire logic in_low   = !is_active(state_reg) && state_reg != ST_RESET
                         && state_reg != ST_ENTER && state_reg != ST_WAKE;
   wire logic [2:0] req_now = wait_for_interrupt_instruction ? REQ_STBY : ctrl_req_reg;

   // ************************************************************
   // sequencer state machine
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_RESET;
         origin_reg    <= ST_TOP;
         target_reg    <= ST_TOP;
         cnt_reg       <= 21'h000000;
         wake_pend_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_RESET: begin
               state_reg  <= ST_TOP;
               target_reg <= ST_TOP;
            end
            ST_TOP, ST_MID, ST_LOW: begin
               // only a software request leaves an active state
               if (req_now != REQ_NONE && req_now != REQ_ACTIVE
                   && low_of(state_reg, req_now) != state_reg) begin
                  origin_reg    <= state_reg;
                  target_reg    <= low_of(state_reg, req_now);
                  state_reg     <= ST_ENTER;
                  cnt_reg       <= 21'(ENTER_CYC - 1);
                  wake_pend_reg <= 1'b0;
               end else if (req_now == REQ_ACTIVE && state_reg != ST_TOP) begin
                  state_reg <= pss_state_t'(state_reg - 4'h1);
               end else if (ctrl_req_reg == 3'h6 && state_reg != ST_LOW) begin
                  state_reg <= pss_state_t'(state_reg + 4'h1);
               end
            end
            ST_ENTER: begin
               if (wake_hit) begin
                  wake_pend_reg <= 1'b1;
               end
               if (cnt_reg == 21'h000000) begin
                  state_reg <= target_reg;
               end else begin
                  cnt_reg <= cnt_reg - 21'h000001;
               end
            end
            ST_GATED, ST_TOP_STBY, ST_MID_STBY, ST_LOW_STBY,
            ST_TOP_SLEEP, ST_MID_SLEEP, ST_LOW_SLEEP, ST_SHUTDOWN: begin
               if (wake_hit || wake_pend_reg) begin
                  wake_pend_reg <= 1'b0;
                  state_reg     <= ST_WAKE;
                  // shutdown restarts in full performance, others go back
                  target_reg    <= (state_reg == ST_SHUTDOWN) ? ST_TOP :
                                   (state_reg == ST_GATED) ? ST_LOW : origin_reg;
                  cnt_reg       <= (state_reg == ST_SHUTDOWN || origin_reg == ST_TOP)
                                   ? 21'(WAKE_LONG_CYC - 1)
                                   : 21'(WAKE_SHORT_CYC - 1);
               end
            end
            ST_WAKE: begin
               if (cnt_reg == 21'h000000) begin
                  state_reg <= target_reg;
               end else begin
                  cnt_reg <= cnt_reg - 21'h000001;
               end
            end
            default: state_reg <= ST_RESET;
         endcase
      end
   end

   // ************************************************************
   // peripheral config reset on sleep exit
   // ************************************************************
   logic from_sleep_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         from_sleep_reg <= 1'b0;
         periph_cfg_rst <= 1'b0;
      end else begin
         if (in_low) begin
            from_sleep_reg <= is_sleep(state_reg) || state_reg == ST_SHUTDOWN;
         end
         periph_cfg_rst <= (state_reg == ST_WAKE) && (cnt_reg == 21'h000000)
                           && from_sleep_reg;
      end
   end

   // ************************************************************
   // apb register writes
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_req_reg <= REQ_NONE;
         pll_en_reg   <= 1'b0;
         deep_reg     <= 1'b0;
         lmem_reg     <= LMEM_RESET;
         smem_reg     <= SMEM_RESET;
         store_reg    <= STORE_RESET;
         wakeen_reg   <= WAKEEN_RESET;
         vsel_reg     <= {VSRC_SC, VSRC_MAIN, VSRC_MAIN, VSRC_MAIN,
                          VSRC_MAIN, VSRC_MAIN, VSRC_MAIN};
      end else begin
         ctrl_req_reg <= REQ_NONE; // request bits self-clear
         if (wr && paddr == PSS_CTRL_OFF) begin
            ctrl_req_reg <= pwdata[2:0];
            pll_en_reg   <= pwdata[4];
            deep_reg     <= pwdata[5];
         end
         if (wr && is_active(state_reg)) begin
            if (paddr == PSS_LMEM_OFF) begin
               lmem_reg <= pwdata[LMEM_DOMAINS-1:0];
            end
            if (paddr == PSS_SMEM_OFF) begin
               smem_reg <= pwdata[SMEM_DOMAINS-1:0];
            end
            if (paddr == PSS_STORE_OFF) begin
               store_reg <= pwdata[STORE_SETS-1:0];
            end
         end
         if (wr && paddr == PSS_WAKEEN_OFF) begin
            wakeen_reg <= pwdata[WAKE_SRCS-1:0];
         end
         if (wr && paddr == PSS_VSEL_OFF) begin
            vsel_reg <= pwdata[13:0];
            vsel_reg[2*VDOM_HIGH +: 2] <= VSRC_MAIN;
            vsel_reg[2*VDOM_UULP +: 2] <= VSRC_SC;
            if (pwdata[3:2] == VSRC_LV || pwdata[3:2] == VSRC_OFF) begin
               vsel_reg[3:2] <= VSRC_MAIN;
            end
         end
      end
   end

   // ************************************************************
   // memory loss tracking
   // ************************************************************
   logic [13:0] large_memory_domains_w;
   wire logic [13:0] pwr_now = {smem_reg, lmem_reg};
   wire logic        deep_now = deep_reg && (is_sleep(state_reg) || state_reg == ST_SHUTDOWN);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lost_reg <= 14'h0000;
      end else begin
         // loss is sticky until software clears it by writing ones
         if (wr && paddr == PSS_STATUS_OFF) begin
            lost_reg <= lost_reg & ~pwdata[29:16];
         end
         if (deep_now) begin
            lost_reg <= 14'h3FFF;
         end else begin
            for (int i = 0; i < 14; i++) begin
               if (!pwr_now[i] || !large_memory_domains_w[i]) begin
                  lost_reg[i] <= 1'b1;
               end
            end
         end
      end
   end

   // ************************************************************
   // controlled outputs
   // ************************************************************
   logic [13:0] vsrc_w;
   always_comb begin
      vsrc_w = vsel_reg;
      if (is_sleep(state_reg) || state_reg == ST_SHUTDOWN) begin
         for (int d = 0; d < VDOMAINS; d++) begin
            if (vsel_reg[2*d +: 2] == VSRC_MAIN) begin
               vsrc_w[2*d +: 2] = VSRC_OFF;
            end
         end
      end
      large_memory_domains_w = pwr_now;
      if (deep_now || state_reg == ST_SHUTDOWN) begin
         large_memory_domains_w = 14'h0000;
      end
      for (int d = 0; d < VDOMAINS; d++) begin
         if (vsrc_w[2*d +: 2] == VSRC_OFF) begin
            if (d == 2) large_memory_domains_w[3:0] = 4'h0;
            if (d == 3) large_memory_domains_w[9:4] = 6'h00;
            if (d == 5) large_memory_domains_w[13:10] = 4'h0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clk_en           <= 1'b1;
         cpu_pwr_en           <= 1'b1;
         fast_pll_sel         <= 1'b0;
         large_memory_domains <= LMEM_RESET;
         small_memory_domains <= SMEM_RESET;
         storage_flop_sets    <= STORE_RESET;
         sram_access_block    <= 1'b0;
         sram_lost            <= 14'h0000;
         vsrc_sel             <= 14'h2555;
         prdata               <= 32'h00000000;
         pready               <= 1'b0;
         pslverr              <= 1'b0;
      end else begin
         // codes reset..low: no dip after reset
         cpu_clk_en <= (state_reg <= ST_LOW);
         cpu_pwr_en <= !(state_reg == ST_GATED || is_sleep(state_reg)
                         || state_reg == ST_SHUTDOWN);
         fast_pll_sel <= pll_en_reg && state_reg == ST_TOP;
         large_memory_domains <= large_memory_domains_w[9:0];
         small_memory_domains <= large_memory_domains_w[13:10];
         storage_flop_sets    <= store_reg;
         sram_access_block    <= deep_now || state_reg == ST_SHUTDOWN;
         sram_lost            <= lost_reg;
         vsrc_sel             <= vsrc_w;
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~rd_ok;
         prdata  <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               PSS_CTRL_OFF:   prdata <= {26'h0, deep_reg, pll_en_reg, 4'h0};
               PSS_STATUS_OFF: prdata <= {2'b00, lost_reg, 8'h00,
                                          wake_pend_reg, 3'h0, state_reg};
               PSS_LMEM_OFF:   prdata <= {22'h0, lmem_reg};
               PSS_SMEM_OFF:   prdata <= {28'h0, smem_reg};
               PSS_STORE_OFF:  prdata <= {29'h0, store_reg};
               PSS_WAKEEN_OFF: prdata <= {16'h0, wakeen_reg};
               PSS_VSEL_OFF:   prdata <= {18'h0, vsel_reg};
               default:        prdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

// ==== tb/pss_seq_assertions.sv ====
// concurrent checks on the power-state sequencer ports
`timescale 1ns/1ps
module pss_seq_checker
   import pss_pkg::*;
(
   input wire logic        mclk,                           // clock
   input wire logic        rst_n,                          // reset, active low
   input wire logic        psel,                           // apb select
   input wire logic        penable,                        // apb access
   input wire logic        pwrite,                         // apb write
   input wire logic [11:0] paddr,                          // apb address
   input wire logic [31:0] pwdata,                         // apb write data
   input wire logic        pready,                         // apb ready
   input wire logic        pslverr,                        // apb error
   input wire logic        wait_for_interrupt_instruction, // standby request
   input wire logic        cpu_clk_en,                     // cpu clock enable
   input wire logic        cpu_pwr_en,                     // cpu power enable
   input wire logic        fast_pll_sel,                   // fast pll in use
   input wire logic        periph_cfg_rst,                 // config reset pulse
   input wire logic [9:0]  large_memory_domains,           // large enables
   input wire logic [3:0]  small_memory_domains,           // small enables
   input wire logic [2:0]  storage_flop_sets,              // storage enables
   input wire logic        sram_access_block,              // access refused
   input wire logic [13:0] sram_lost,                      // lost flags
   input wire logic [13:0] vsrc_sel                        // voltage sources
);
   wire logic        req_w;
   wire logic [13:0] lost_due;
   // any software request that may start a low-power entry
   assign req_w = (psel & penable & pwrite & (paddr == PSS_CTRL_OFF) & (pwdata[2:0] != 3'h0))
                  | wait_for_interrupt_instruction;
   assign lost_due = ~{small_memory_domains, large_memory_domains} & ~sram_lost;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_reset_on: assert property ($rose(rst_n) |-> large_memory_domains == 10'h3FF
      && small_memory_domains == 4'hF && storage_flop_sets == 3'h7 && cpu_pwr_en)
      else $error("domains not on after reset");
   chk_clk_cause: assert property ($fell(cpu_clk_en)
      |-> $past(req_w) || $past(req_w, 2) || $past(req_w, 3))
      else $error("clock gated without request");
   chk_pll_clocked: assert property (fast_pll_sel |-> cpu_clk_en && cpu_pwr_en)
      else $error("fast pll outside running state");
   chk_block_off: assert property (sram_access_block |-> !cpu_clk_en && !cpu_pwr_en)
      else $error("memory blocked while cpu up");
   chk_lost_flag: assert property (lost_due != 14'h0 |-> ##[1:2] lost_due == 14'h0)
      else $error("powered-down domain not marked lost");
   chk_high_src: assert property (vsrc_sel[3:2] inside {VSRC_OFF, VSRC_MAIN})
      else $error("high domain source illegal");
   chk_uulp_src: assert property (vsrc_sel[13:12] == VSRC_SC)
      else $error("always-on domain source illegal");
   chk_cfg_pulse: assert property (periph_cfg_rst |=> !periph_cfg_rst)
      else $error("config reset longer than one cycle");
   cover property (sram_access_block);
   cover property ($rose(periph_cfg_rst));
   cover property ($fell(cpu_clk_en) && cpu_pwr_en);
endmodule

// ==== tb/pss_core_model.sv ====
// processor core model: apb master and standby instruction
`timescale 1ns/1ps
module pss_core_model (
   input  wire logic        mclk,    // clock
   output logic             psel,    // apb select
   output logic             penable, // apb access
   output logic             pwrite,  // apb write
   output logic [11:0]      paddr,   // apb address
   output logic [31:0]      pwdata,  // apb write data
   input  wire logic [31:0] prdata,  // apb read data
   input  wire logic        pready,  // apb ready
   input  wire logic        pslverr, // apb error
   output logic             wait_for_interrupt_instruction // standby request
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      wait_for_interrupt_instruction = 1'b0;
   end
   // low-power requests only ever come from these calls
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show the inverse, never a stale value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   task automatic standby_req();
      @(posedge mclk);
      wait_for_interrupt_instruction <= 1'b1;
      @(posedge mclk);
      wait_for_interrupt_instruction <= 1'b0;
   endtask
endmodule

// ==== tb/pss_sequencer_bench.sv ====
// self-checking bench for the power-state sequencer
`timescale 1ns/1ps
module pss_sequencer_bench;
   import pss_pkg::*;
   logic mclk = 1'b0, rst_n = 1'b0, e;
   logic psel, penable, pwrite, pready, pslverr, stby;
   logic cpu_clk_en, cpu_pwr_en, fast_pll_sel, periph_cfg_rst, sram_access_block;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] wake_irq = 16'h0000;
   logic [9:0]  lmem;
   logic [3:0]  smem;
   logic [2:0]  store;
   logic [13:0] sram_lost, vsrc_sel;
   int fail_count = 0, n_compared = 0, cyc = 0, cfg_n = 0;
   always #20 mclk = ~mclk;
   pss_core_model u_core (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wait_for_interrupt_instruction(stby));
   pss_sequencer #(.WAKE_LONG_CYC(20), .WAKE_SHORT_CYC(10)) DUT (.mclk(mclk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_for_interrupt_instruction(stby),
      .wake_irq(wake_irq), .cpu_clk_en(cpu_clk_en), .cpu_pwr_en(cpu_pwr_en),
      .fast_pll_sel(fast_pll_sel), .periph_cfg_rst(periph_cfg_rst), .large_memory_domains(lmem),
      .small_memory_domains(smem), .storage_flop_sets(store),
      .sram_access_block(sram_access_block), .sram_lost(sram_lost), .vsrc_sel(vsrc_sel));
   always @(posedge mclk) begin
      if (periph_cfg_rst === 1'b1) cfg_n <= cfg_n + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_core.xfer(1'b1, a, d, q, e);
   endtask
   task automatic wait_state(input logic [3:0] v);
      int n;
      n = 0;
      do begin
         u_core.xfer(1'b0, PSS_STATUS_OFF, 32'h0, q, e);
         n++;
      end while (q[3:0] !== v && n < 200);
      check("state", {28'h0, q[3:0]}, {28'h0, v});
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   logic [11:0] offs [5] = '{PSS_LMEM_OFF, PSS_SMEM_OFF, PSS_STORE_OFF, PSS_WAKEEN_OFF, PSS_VSEL_OFF};
   logic [31:0] rstv [5] = '{32'h3FF, 32'hF, 32'h7, 32'h0, 32'h2555};
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      check("enables", {lmem, smem, store}, 32'h1FFFF);
      wait_state(4'h1);
      check("vsrc", vsrc_sel, 32'h2555);
      for (int i = 0; i < 5; i++) begin
         u_core.xfer(1'b0, offs[i], 32'h0, q, e);
         check("reg reset", q, rstv[i]);
      end
      u_core.xfer(1'b0, 12'h01C, 32'h0, q, e);
      check("unmapped", {q[30:0], e}, 32'h1);
      wr(PSS_LMEM_OFF, 32'h3FE);
      repeat (2) @(posedge mclk);
      check("large off", lmem, 32'h3FE);
      u_core.xfer(1'b0, PSS_STATUS_OFF, 32'h0, q, e);
      check("lost", q[16], 1'b1);
      wr(PSS_LMEM_OFF, 32'h3FF);
      wr(PSS_WAKEEN_OFF, 32'h0101);
      wr(PSS_CTRL_OFF, 32'h16);
      wait_state(4'h2);
      check("pll low", {fast_pll_sel, cpu_clk_en}, 32'h1);
      wr(PSS_CTRL_OFF, 32'h11);
      wait_state(4'h1);
      check("pll on", fast_pll_sel, 1'b1);
      u_core.standby_req();
      wait_state(4'h5);
      check("standby", {cpu_clk_en, cpu_pwr_en}, 32'h1);
      wake_irq <= 16'h0002;
      repeat (30) @(posedge mclk);
      wait_state(4'h5);
      wake_irq <= 16'h0001;
      wait_state(4'h1);
      wake_irq <= 16'h0000;
      wr(PSS_CTRL_OFF, 32'h3);
      wait_state(4'h8);
      check("sleep src", {vsrc_sel[3:2], cpu_pwr_en}, 32'h0);
      wake_irq <= 16'h0100;
      repeat (30) @(posedge mclk);
      wait_state(4'h8);
      wake_irq <= 16'h0001;
      wait_state(4'h1);
      check("cfg reset", cfg_n, 1);
      wake_irq <= 16'h0000;
      wr(PSS_CTRL_OFF, 32'h24);
      wait_state(4'hB);
      check("blocked", sram_access_block, 1'b1);
      wake_irq <= 16'h0001;
      wait_state(4'h1);
      wr(PSS_CTRL_OFF, 32'h3);
      wait_state(4'h1);
      check("late wake", cfg_n, 3);
      final_report();
   end
endmodule
bind pss_sequencer pss_seq_checker u_chk (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .wait_for_interrupt_instruction, .cpu_clk_en, .cpu_pwr_en,
   .fast_pll_sel, .periph_cfg_rst, .large_memory_domains, .small_memory_domains,
   .storage_flop_sets, .sram_access_block, .sram_lost, .vsrc_sel);
